/* File: dtcu_ext_src.sv */
`timescale 1ns/10ps
// ============================================================
// Burst of falling edges on a pulled-up count pin.
module dtcu_ext_src (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [7:0] n_edges,
  input  wire logic [5:0] half,
  output logic            ext_out,
  output logic            busy
);
  logic [8:0] left;
  logic [5:0] cnt;
  logic [5:0] lim;
  assign lim = (half < 6'h06) ? 6'h06 : half;
  initial begin
    ext_out = 1'b1;
    busy    = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (go && !busy) begin
      left <= {n_edges, 1'b0};
      cnt  <= lim;
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt > 6'h01) cnt <= cnt - 6'h01;
      else if (left == 9'h000) busy <= 1'b0;
      else begin
        ext_out <= ~ext_out;
        left    <= left - 9'h001;
        cnt     <= lim;
      end
    end
  end
endmodule

/* File: dtcu_pkg.sv */
package dtcu_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each).
  localparam logic [3:0] OFF_MODE   = 4'h0;
  localparam logic [3:0] OFF_CTRL   = 4'h4;
  localparam logic [3:0] OFF_COUNT0 = 4'h8;
  localparam logic [3:0] OFF_COUNT1 = 4'hc;

  // ==========================================================================
  // Mode register fields, per timer nibble.
  localparam int MODE_LO_POS   = 0;
  localparam int MODE_HI_POS   = 1;
  localparam int SRC_POS       = 2;
  localparam int GATE_POS      = 3;
  localparam int NIBBLE_W      = 4;

  // Control register fields.
  localparam int RUN0_POS      = 0;
  localparam int RUN1_POS      = 1;
  localparam int OVF0_POS      = 4;
  localparam int OVF1_POS      = 5;
  localparam int OVFH_POS      = 6;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // ==========================================================================
  // Timing.
  localparam int OSC_PER_MC   = 6;
  localparam int PRESCALE_DIV = 32;

  typedef enum logic [1:0] {
    DTCU_M13 = 2'b00,
    DTCU_M16 = 2'b01,
    DTCU_M8R = 2'b10,
    DTCU_MSP = 2'b11
  } dtcu_mode_e;

  typedef struct packed {
    logic [1:0] mode;
    logic       src_ext;
    logic       gate_en;
  } dtcu_cfg_s;

endpackage

/* File: dtcu_properties.sv */
`timescale 1ns/10ps
// ============================================================
// Checker on the top module ports.
module dtcu_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ext_count_in0,
  input wire logic        ext_count_in1,
  input wire logic        gate_in0,
  input wire logic        gate_in1,
  input wire logic        ovf0_q,
  input wire logic        ovf1_q
);
  logic req;
  logic wr_ctl;
  assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctl = req & wb_we_i & (wb_adr_i == dtcu_pkg::OFF_CTRL);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ack; req |=> wb_ack_o; endproperty
  property p_one; wb_ack_o |=> !wb_ack_o; endproperty
  property p_cause; wb_ack_o |-> $past(req); endproperty
  property p_rst;
    disable iff (1'b0) !rst_n |=> !wb_ack_o && !ovf0_q && !ovf1_q && wb_dat_o == 32'h0;
  endproperty
  property p_keep0; ovf0_q && !wr_ctl |=> ovf0_q; endproperty
  property p_keep1; ovf1_q && !wr_ctl |=> ovf1_q; endproperty
  property p_hold; !req [*2] |-> $stable(wb_dat_o); endproperty
  property p_unmap; req && !wb_we_i && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0; endproperty
  property p_ctl_rd;
    req && !wb_we_i && wb_adr_i == dtcu_pkg::OFF_CTRL && ovf0_q |=> wb_dat_o[4];
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_one: assert property (p_one) else $error("ack longer than one cycle");
  a_cause: assert property (p_cause) else $error("ack without request");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_keep0: assert property (p_keep0) else $error("overflow 0 lost");
  a_keep1: assert property (p_keep1) else $error("overflow 1 lost");
  a_hold: assert property (p_hold) else $error("read data changed while idle");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read misses overflow");
  c_wr: cover property (req && wb_we_i);
  c_ovf: cover property ($rose(ovf0_q));
  c_clr: cover property ($fell(ovf0_q));
endmodule
bind dtcu_top dtcu_chk dtcu_chk_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_in0(ext_count_in0),
  .ext_count_in1(ext_count_in1), .gate_in0(gate_in0), .gate_in1(gate_in1),
  .ovf0_q(ovf0_q), .ovf1_q(ovf1_q)
);

/* File: dtcu_tmr.sv */
`timescale 1ns/10ps
module dtcu_tmr (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              tick,
  input  wire dtcu_pkg::dtcu_cfg_s cfg,
  input  wire logic              run,
  input  wire logic              gate_lvl,
  input  wire logic              ext_in,
  input  wire logic              halt,
  input  wire logic              wr_en,
  input  wire logic [15:0]       wr_data,
  output logic [15:0]            count_q,
  output logic                   ovf_pulse_q
);

  // ==========================================================================
  // Edge detection and gating.
  logic        ext_s_q;
  logic        ext_s_d;
  logic        ext_fall;
  logic        enable;
  logic        inc;
  logic [15:0] count_d;
  logic        ovf_d;

  always_comb begin
    ext_s_d  = tick ? ext_in : ext_s_q; // RULE_07
    ext_fall = tick && ext_s_q && !ext_in; // RULE_06
    enable   = run && (!cfg.gate_en || gate_lvl) && !halt; // RULE_08 RULE_10
    inc      = enable && (cfg.src_ext ? ext_fall : tick); // RULE_05
  end

  // ==========================================================================
  // Count update per mode.
  always_comb begin
    count_d = count_q;
    ovf_d   = 1'b0;
    if (wr_en) begin
      count_d = wr_data;
    end else if (inc) begin
      case (cfg.mode) // RULE_01
        2'b00: begin // RULE_02
          count_d[4:0] = count_q[4:0] + 5'h01;
          if (count_q[4:0] == 5'(dtcu_pkg::PRESCALE_DIV - 1)) begin
            count_d[15:8] = count_q[15:8] + 8'h01;
            ovf_d         = (count_q[15:8] == 8'hff); // RULE_09
          end
        end
        2'b01: begin
          count_d = count_q + 16'h0001;
          ovf_d   = (count_q == 16'hffff);
        end
        2'b10: begin // RULE_03
          if (count_q[7:0] == 8'hff) begin
            count_d[7:0] = count_q[15:8];
            ovf_d        = 1'b1;
          end else begin
            count_d[7:0] = count_q[7:0] + 8'h01;
          end
        end
        default: begin // RULE_04
          count_d[7:0] = count_q[7:0] + 8'h01;
          ovf_d        = (count_q[7:0] == 8'hff);
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_q     <= dtcu_pkg::COUNT_RST;
      ext_s_q     <= 1'b0;
      ovf_pulse_q <= 1'b0;
    end else begin
      count_q     <= count_d;
      ext_s_q     <= ext_s_d;
      ovf_pulse_q <= ovf_d;
    end
  end

endmodule

/* File: dtcu_top.sv */
// Behaviour
// [RULE_01] Two-bit mode field picks mode 0, 1 (16-bit), 2 or 3.
// [RULE_02] Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// [RULE_03] Mode 2 is an 8-bit counter reloading an 8-bit value on rollover.
// [RULE_04] Mode 3 splits timer 0 into two 8-bit timers; timer 1 stops.
// [RULE_05] Timer function increments once per machine cycle of six clocks.
// [RULE_06] Counter function increments on falling edges at the external input.
// [RULE_07] Edge recognition takes two machine cycles; source must stay below clk/12.
// [RULE_08] Gate inputs may gate their timer for pulse width measurement.
// [RULE_09] Rollover to zero sets the timer's overflow flag.
// [RULE_10] With gating on, counting needs run set and gate input high.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module dtcu_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_count_in0,
  input  wire logic        ext_count_in1,
  input  wire logic        gate_in0,
  input  wire logic        gate_in1,
  output logic             ovf0_q,
  output logic             ovf1_q
);

  // ==========================================================================
  // Machine-cycle divider.
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic       tick;

  always_comb begin
    tick  = (div_q == 3'(dtcu_pkg::OSC_PER_MC - 1)); // RULE_05
    div_d = tick ? 3'h0 : div_q + 3'h1;
  end

  // ==========================================================================
  // Registers.
  logic [7:0]  timer_mode_reg_q;
  logic [7:0]  timer_mode_reg_d;
  logic [1:0]  run_q;
  logic [1:0]  run_d;
  logic        ovfh_q;
  logic        ovfh_d;
  logic        ovf0_d;
  logic        ovf1_d;
  logic [31:0] dat_d;
  logic        ack_d;
  logic        acc;
  logic        wr;
  logic        wr0;
  logic        wr1;
  logic        wr_hi;
  logic [15:0] cnt0;
  logic [15:0] cnt1;
  logic        p0;
  logic        p1;
  logic        hi_inc;
  logic [15:0] wdat16;
  dtcu_pkg::dtcu_cfg_s cfg0;
  dtcu_pkg::dtcu_cfg_s cfg1;
  logic        split;

  // Mode 3 high half of timer 0: extra 8-bit timer with run1 as control.
  logic [7:0]  hi_q;
  logic [7:0]  hi_d;
  logic        hi_wrap;
  logic        wr_mode;
  logic        wr_ctrl;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // ==========================================================================
  // Bus decode and timer configuration.
  always_comb begin
    acc          = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr           = acc && wb_we_i && wb_sel_i[0];
    cfg0.mode    = {timer_mode_reg_q[dtcu_pkg::MODE_HI_POS],
                    timer_mode_reg_q[dtcu_pkg::MODE_LO_POS]}; // RULE_01
    cfg0.src_ext = timer_mode_reg_q[dtcu_pkg::SRC_POS];
    cfg0.gate_en = timer_mode_reg_q[dtcu_pkg::GATE_POS];
    cfg1.mode    = {timer_mode_reg_q[dtcu_pkg::NIBBLE_W + dtcu_pkg::MODE_HI_POS],
                    timer_mode_reg_q[dtcu_pkg::NIBBLE_W + dtcu_pkg::MODE_LO_POS]};
    cfg1.src_ext = timer_mode_reg_q[dtcu_pkg::NIBBLE_W + dtcu_pkg::SRC_POS];
    cfg1.gate_en = timer_mode_reg_q[dtcu_pkg::NIBBLE_W + dtcu_pkg::GATE_POS];
    split        = (cfg0.mode == 2'b11); // RULE_04
    wdat16       = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_dat_i[7:0]};
    wr0          = wr && (wb_adr_i == dtcu_pkg::OFF_COUNT0);
    wr1          = wr && (wb_adr_i == dtcu_pkg::OFF_COUNT1);
    wr_hi        = wr0 && wb_sel_i[1] && split;
    wr_mode      = wr && (wb_adr_i == dtcu_pkg::OFF_MODE);
    wr_ctrl      = wr && (wb_adr_i == dtcu_pkg::OFF_CTRL);
  end

  // ==========================================================================
  // Mode and run control.
  always_comb begin
    timer_mode_reg_d = wr_mode ? wb_dat_i[7:0] : timer_mode_reg_q;
    run_d            = wr_ctrl ? wb_dat_i[dtcu_pkg::RUN1_POS:dtcu_pkg::RUN0_POS] : run_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timer_mode_reg_q <= dtcu_pkg::MODE_RST;
      run_q            <= 2'b00;
    end else begin
      timer_mode_reg_q <= timer_mode_reg_d;
      run_q            <= run_d;
    end
  end

  // ==========================================================================
  // Free 8-bit timer in the high half of timer 0 while split.
  always_comb begin
    hi_inc = split && run_q[1] && tick; // RULE_04
    hi_d   = hi_q;
    if (wr_hi) begin
      hi_d = wb_dat_i[15:8];
    end else if (hi_inc) begin
      hi_d = hi_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= hi_d;
    end
  end

  // ==========================================================================
  // Sticky overflow flags; a set wins over a clear in the same cycle.
  always_comb begin
    hi_wrap = hi_inc && (hi_q == 8'hff);
    ovf0_d  = ovf0_q | p0; // RULE_09
    ovf1_d  = ovf1_q | (p1 && !split);
    ovfh_d  = ovfh_q | hi_wrap;
    if (wr_ctrl && wb_dat_i[dtcu_pkg::OVF0_POS]) begin
      ovf0_d = p0;
    end
    if (wr_ctrl && wb_dat_i[dtcu_pkg::OVF1_POS]) begin
      ovf1_d = p1 && !split;
    end
    if (wr_ctrl && wb_dat_i[dtcu_pkg::OVFH_POS]) begin
      ovfh_d = hi_wrap;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ovf0_q <= 1'b0;
      ovf1_q <= 1'b0;
      ovfh_q <= 1'b0;
    end else begin
      ovf0_q <= ovf0_d;
      ovf1_q <= ovf1_d;
      ovfh_q <= ovfh_d;
    end
  end

  // ==========================================================================
  // Bus response.
  always_comb begin
    ack_d = acc;
    dat_d = wb_dat_o;
    if (acc) begin
      case (wb_adr_i)
        dtcu_pkg::OFF_MODE:   dat_d = {24'h0, timer_mode_reg_q};
        dtcu_pkg::OFF_CTRL:   dat_d = {25'h0, ovfh_q, ovf1_q, ovf0_q, 2'b00, run_q};
        dtcu_pkg::OFF_COUNT0: dat_d = {16'h0, split ? hi_q : cnt0[15:8], cnt0[7:0]};
        dtcu_pkg::OFF_COUNT1: dat_d = {16'h0, cnt1};
        default:              dat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
    end
  end

  // ==========================================================================
  // Timer instances.
  dtcu_tmr u_tmr0 (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .tick        (tick),
    .cfg         (cfg0),
    .run         (run_q[0]),
    .gate_lvl    (gate_in0),
    .ext_in      (ext_count_in0),
    .halt        (1'b0),
    .wr_en       (wr0),
    .wr_data     (wdat16),
    .count_q     (cnt0),
    .ovf_pulse_q (p0)
  );

  dtcu_tmr u_tmr1 (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .tick        (tick),
    .cfg         (cfg1),
    .run         (run_q[1]),
    .gate_lvl    (gate_in1),
    .ext_in      (ext_count_in1),
    .halt        (split || cfg1.mode == 2'b11), // RULE_04
    .wr_en       (wr1),
    .wr_data     (wdat16),
    .count_q     (cnt1),
    .ovf_pulse_q (p1)
  );

endmodule

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
  logic        clk_sys;
  logic        rst_n = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [3:0]  wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        gate0 = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  n_edges = 8'h00;
  logic        ext;
  logic        busy;
  logic        ovf0_q;
  logic        ovf1_q;
  logic [31:0] q;
  int          errors = 0;
  int          checks_done = 0;
  dtcu_top dtcu_top_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_in0(ext), .ext_count_in1(ext),
    .gate_in0(gate0), .gate_in1(1'b0), .ovf0_q(ovf0_q), .ovf1_q(ovf1_q)
  );
  dtcu_ext_src dtcu_ext_src_inst (
    .clk_sys(clk_sys), .go(go), .n_edges(n_edges), .half(6'h08), .ext_out(ext), .busy(busy)
  );
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ============================================================
  // Bus cycles and checks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic pulses(input logic [7:0] n);
    n_edges <= n;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ============================================================
  // Scenarios.
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 4'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    acc(1'b0, 4'h1, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, dtcu_pkg::OFF_MODE, 32'h55);
    acc(1'b1, dtcu_pkg::OFF_CTRL, 32'h3);
    pulses(8'h05);
    acc(1'b0, dtcu_pkg::OFF_COUNT0, 32'h0);
    chk(q, 32'h5);
    acc(1'b0, dtcu_pkg::OFF_COUNT1, 32'h0);
    chk(q, 32'h5);
    acc(1'b1, dtcu_pkg::OFF_MODE, 32'h44);
    acc(1'b1, dtcu_pkg::OFF_COUNT0, 32'h0);
    pulses(8'h21);
    acc(1'b0, dtcu_pkg::OFF_COUNT0, 32'h0);
    chk(q, 32'h101);
    acc(1'b1, dtcu_pkg::OFF_MODE, 32'h46);
    acc(1'b1, dtcu_pkg::OFF_COUNT0, 32'hf0fe);
    pulses(8'h04);
    acc(1'b0, dtcu_pkg::OFF_COUNT0, 32'h0);
    chk(q, 32'hf0f2);
    chk(32'(ovf0_q), 32'h1);
    acc(1'b0, dtcu_pkg::OFF_CTRL, 32'h0);
    chk(q, 32'h13);
    acc(1'b1, dtcu_pkg::OFF_CTRL, 32'h13);
    chk(32'(ovf0_q), 32'h0);
    acc(1'b1, dtcu_pkg::OFF_MODE, 32'h0d);
    acc(1'b1, dtcu_pkg::OFF_COUNT0, 32'h0);
    pulses(8'h03);
    acc(1'b0, dtcu_pkg::OFF_COUNT0, 32'h0);
    chk(q, 32'h0);
    gate0 <= 1'b1;
    pulses(8'h03);
    acc(1'b0, dtcu_pkg::OFF_COUNT0, 32'h0);
    chk(q, 32'h3);
    acc(1'b1, dtcu_pkg::OFF_MODE, 32'h57);
    acc(1'b1, dtcu_pkg::OFF_COUNT0, 32'h0);
    acc(1'b1, dtcu_pkg::OFF_COUNT1, 32'h0);
    pulses(8'h05);
    acc(1'b0, dtcu_pkg::OFF_COUNT0, 32'h0);
    chk(q & 32'hff, 32'h5);
    acc(1'b0, dtcu_pkg::OFF_COUNT1, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, dtcu_pkg::OFF_CTRL, 32'h0);
    acc(1'b1, dtcu_pkg::OFF_MODE, 32'h01);
    acc(1'b1, dtcu_pkg::OFF_COUNT0, 32'h0);
    acc(1'b1, dtcu_pkg::OFF_CTRL, 32'h1);
    repeat (60) @(posedge clk_sys);
    acc(1'b1, dtcu_pkg::OFF_CTRL, 32'h0);
    acc(1'b0, dtcu_pkg::OFF_COUNT0, 32'h0);
    chk(32'(q >= 32'h9 && q <= 32'hb), 32'h1);
    acc(1'b1, dtcu_pkg::OFF_MODE, 32'h10);
    acc(1'b1, dtcu_pkg::OFF_COUNT1, 32'hfffe);
    acc(1'b1, dtcu_pkg::OFF_CTRL, 32'h20);
    chk(32'(ovf1_q), 32'h0);
    acc(1'b1, dtcu_pkg::OFF_CTRL, 32'h2);
    repeat (20) @(posedge clk_sys);
    chk(32'(ovf1_q), 32'h1);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    print_verdict;
  end
endmodule
